// ===== core/apc_audio_port.sv
// Audio port clock configuration: clock output divider, bit clock divider,
// serial port framing and the AXI4-Lite register file.
// Assumes source clocks arrive as one-cycle ticks synchronous to clk.
`timescale 1ns/1ps
module apc_audio_port import apc_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire apc_axi_req_s axiReq,
  output apc_axi_rsp_s axiRsp,
  // Source clock ticks and converter power state
  input wire logic mclkTick,
  input wire logic pllTick,
  input wire logic adcTick,
  input wire logic modTick,
  input wire logic converterPowered,
  // Auxiliary clock pin
  output logic auxClkOut,
  // Bit clock pin
  input wire logic bclkIn,
  output logic bclkOut,
  output logic bclkOe,
  // Word clock pin
  input wire logic wclkIn,
  output logic wclkOut,
  output logic wclkOe,
  // Serial data
  input wire logic [31:0] sampleLeft,
  input wire logic [31:0] sampleRight,
  output logic sampleTaken,
  output logic doutOut,
  output logic doutOe
);

  logic [7:0] clkSel_reg, clkDiv_reg, portFmt_reg, slotOfs_reg;
  logic [7:0] portClk_reg, bclkDiv_reg;
  logic awHeld_reg, wHeld_reg;
  logic [7:0] awIdx_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic bValid_reg, rValid_reg;
  logic [1:0] bResp_reg, rResp_reg;
  logic [31:0] rData_reg;
  logic [7:0] rdByte;
  logic rdHit;
  logic doWrite;
  logic [7:0] arIdx;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data taken in either order
  assign axiRsp.awready = !awHeld_reg && !bValid_reg;
  assign axiRsp.wready = !wHeld_reg && !bValid_reg;
  assign axiRsp.bvalid = bValid_reg;
  assign axiRsp.bresp = bResp_reg;
  assign axiRsp.arready = !rValid_reg;
  assign axiRsp.rvalid = rValid_reg;
  assign axiRsp.rresp = rResp_reg;
  assign axiRsp.rdata = rData_reg;
  assign doWrite = awHeld_reg && wHeld_reg && !bValid_reg;
  assign arIdx = axiReq.araddr[9:2];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awIdx_reg <= 8'h00;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
    end else begin
      if (axiReq.awvalid && axiRsp.awready) begin
        awHeld_reg <= 1'b1;
        awIdx_reg <= axiReq.awaddr[9:2];
      end else if (doWrite) begin
        awHeld_reg <= 1'b0;
      end
      if (axiReq.wvalid && axiRsp.wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= axiReq.wdata;
        wStrb_reg <= axiReq.wstrb;
      end else if (doWrite) begin
        wHeld_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bValid_reg <= 1'b0;
      bResp_reg <= RESP_OKAY;
    end else if (doWrite) begin
      bValid_reg <= 1'b1;
      bResp_reg <= (awIdx_reg >= IDX_AUXILIARY_CLOCK_PIN_SEL &&
                    awIdx_reg <= IDX_BCLK_DIV) ? RESP_OKAY : RESP_SLVERR;
    end else if (bValid_reg && axiReq.bready) begin
      bValid_reg <= 1'b0;
    end
  end

  // Only byte lane 0 holds register bits; reserved bits are not storable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clkSel_reg <= RST_AUXILIARY_CLOCK_PIN_SEL;
      clkDiv_reg <= RST_AUXILIARY_CLOCK_PIN_DIV;
      portFmt_reg <= RST_PORT_FMT;
      slotOfs_reg <= RST_SLOT_OFS;
      portClk_reg <= RST_PORT_CLK;
      bclkDiv_reg <= RST_BCLK_DIV;
    end else if (doWrite && wStrb_reg[0]) begin
      case (awIdx_reg)
        IDX_AUXILIARY_CLOCK_PIN_SEL: clkSel_reg <= wData_reg[7:0] & MSK_AUXILIARY_CLOCK_PIN_SEL;
        IDX_AUXILIARY_CLOCK_PIN_DIV: clkDiv_reg <= wData_reg[7:0];
        IDX_PORT_FMT: portFmt_reg <= wData_reg[7:0] & MSK_PORT_FMT;
        IDX_SLOT_OFS: slotOfs_reg <= wData_reg[7:0];
        IDX_PORT_CLK: portClk_reg <= wData_reg[7:0] & MSK_PORT_CLK;
        IDX_BCLK_DIV: bclkDiv_reg <= wData_reg[7:0];
        default: ;
      endcase
    end
  end

  logic [1:0] divRun;
  logic frameActive;

  always_comb begin
    rdHit = 1'b1;
    rdByte = 8'h00;
    case (arIdx)
      IDX_RSVD_A, IDX_RSVD_B: rdByte = 8'h00;
      IDX_AUXILIARY_CLOCK_PIN_SEL: rdByte = clkSel_reg;
      IDX_AUXILIARY_CLOCK_PIN_DIV: rdByte = clkDiv_reg;
      IDX_PORT_FMT: rdByte = portFmt_reg;
      IDX_SLOT_OFS: rdByte = slotOfs_reg;
      IDX_PORT_CLK: rdByte = portClk_reg;
      IDX_BCLK_DIV: rdByte = bclkDiv_reg;
      IDX_STATUS: rdByte = {5'b00000, frameActive, divRun};
      default: rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rValid_reg <= 1'b0;
      rResp_reg <= RESP_OKAY;
      rData_reg <= 32'h0000_0000;
    end else if (axiReq.arvalid && axiRsp.arready) begin
      rValid_reg <= 1'b1;
      rResp_reg <= rdHit ? RESP_OKAY : RESP_SLVERR;
      rData_reg <= {24'h00_0000, rdByte};
    end else if (rValid_reg && axiReq.rready) begin
      rValid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock sources and the two dividers
  logic bclkInv, keepAlive, bclkDrive, wclkDrive, triEn;
  logic bclkInPrev_reg, bclkPinRise;
  logic [1:0] srcTick;
  logic [1:0][7:0] divCfg;
  logic [1:0] divTick_reg, divLvl_reg;
  logic [1:0][6:0] divCnt_reg;

  assign bclkInv = portClk_reg[BCLK_INV_BIT];
  assign keepAlive = portClk_reg[KEEP_ALIVE_BIT];
  assign bclkDrive = portFmt_reg[BCLK_DIR_BIT];
  assign wclkDrive = portFmt_reg[WCLK_DIR_BIT];
  assign triEn = portFmt_reg[TRISTATE_BIT];

  // Polarity applied before edge detection, so inversion holds both ways
  always_ff @(posedge clk or posedge rst) begin
    if (rst) bclkInPrev_reg <= 1'b0;
    else bclkInPrev_reg <= bclkIn ^ bclkInv;
  end
  assign bclkPinRise = (bclkIn ^ bclkInv) && !bclkInPrev_reg;

  always_comb begin
    case (clkSel_reg[2:0])
      CSEL_MCLK: srcTick[0] = mclkTick;
      CSEL_BCLK: srcTick[0] = bclkPinRise;
      CSEL_PLL: srcTick[0] = pllTick;
      CSEL_ADC: srcTick[0] = adcTick;
      CSEL_MOD: srcTick[0] = modTick;
      default: srcTick[0] = 1'b0;
    endcase
    case (portClk_reg[1:0])
      BSEL_ADC: srcTick[1] = adcTick;
      BSEL_MOD: srcTick[1] = modTick;
      default: srcTick[1] = 1'b0;
    endcase
  end

  assign divCfg[0] = clkDiv_reg;
  assign divCfg[1] = bclkDiv_reg;
  assign divRun[0] = clkDiv_reg[DIV_PWR_BIT];
  assign divRun[1] = bclkDiv_reg[DIV_PWR_BIT] &&
                     (converterPowered || keepAlive);

  for (genvar d = 0; d < 2; d++) begin : gDiv
    logic [7:0] ratio;
    logic [6:0] last;
    assign ratio = (divCfg[d][6:0] == 7'h00) ? 8'h80
                   : {1'b0, divCfg[d][6:0]};
    assign last = 7'(ratio - 8'h01);
    // Level is high for the first ratio/2 source ticks, rounded down, of each output period, and for one cycle per tick at ratio 1
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        divCnt_reg[d] <= 7'h00;
        divTick_reg[d] <= 1'b0;
        divLvl_reg[d] <= 1'b0;
      end else if (!divRun[d]) begin
        divCnt_reg[d] <= 7'h00;
        divTick_reg[d] <= 1'b0;
        divLvl_reg[d] <= 1'b0;
      end else if (srcTick[d]) begin
        divCnt_reg[d] <= (divCnt_reg[d] == last) ? 7'h00
                         : 7'(divCnt_reg[d] + 7'h01);
        divTick_reg[d] <= (divCnt_reg[d] == 7'h00);
        divLvl_reg[d] <= ({1'b0, divCnt_reg[d]} < (ratio >> 1)) ||
                         (ratio == 8'h01);
      end else begin
        divTick_reg[d] <= 1'b0;
        if (ratio == 8'h01) divLvl_reg[d] <= 1'b0;
      end
    end
  end

  assign auxClkOut = divLvl_reg[0];

  ////////////////////////////////////////////////////////////////////////
  // Serial port framing
  apc_fmt_e fmt;
  logic [5:0] wordLen;
  logic [9:0] startBit, frameLen, bitCnt_reg, pos;
  logic bitTick, wclkInPrev_reg, wclkEdge, frameStart;
  logic wclkLvl_reg, dataBit;
  logic [31:0] left_reg, right_reg, leftSrc;
  logic dout_reg, active_reg, bclkLvl_reg;

  assign fmt = apc_fmt_e'(portFmt_reg[FMT_LSB +: 2]);
  always_comb begin
    case (portFmt_reg[WLEN_LSB +: 2])
      2'b00: wordLen = 6'd16;
      2'b01: wordLen = 6'd20;
      2'b10: wordLen = 6'd24;
      default: wordLen = 6'd32;
    endcase
  end

  // I2S data starts one bit late; offset counts from the frame edge
  assign startBit = {2'b00, slotOfs_reg} +
                    ((fmt == FMT_I2S) ? 10'd1 : 10'd0);
  assign frameLen = startBit + {3'b000, wordLen, 1'b0};
  assign bitTick = bclkDrive ? divTick_reg[1] : bclkPinRise;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) wclkInPrev_reg <= 1'b0;
    else if (bitTick) wclkInPrev_reg <= wclkIn;
  end
  // I2S frames open on the falling word clock, the others on the rising
  assign wclkEdge = (fmt == FMT_I2S) ? (wclkInPrev_reg && !wclkIn)
                                     : (!wclkInPrev_reg && wclkIn);
  // A shorter format written mid-frame must not leave the counter past its end
  assign frameStart = bitTick && (wclkDrive ? (bitCnt_reg >= frameLen - 10'd1)
                                            : wclkEdge);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bitCnt_reg <= 10'h000;
    end else if (frameStart) begin
      bitCnt_reg <= 10'h000;
    end else if (bitTick && bitCnt_reg != 10'h3ff) begin
      bitCnt_reg <= 10'(bitCnt_reg + 10'h001);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left_reg <= 32'h0000_0000;
      right_reg <= 32'h0000_0000;
    end else if (frameStart) begin
      left_reg <= sampleLeft;
      right_reg <= sampleRight;
    end
  end
  assign sampleTaken = frameStart;

  assign pos = frameStart ? 10'(10'd0 - startBit)
                          : 10'(bitCnt_reg + 10'd1 - startBit);
  // At a zero start the first bit leaves with the word being captured
  assign leftSrc = frameStart ? sampleLeft : left_reg;
  always_comb begin
    if (pos < {4'h0, wordLen}) dataBit = leftSrc[5'(6'd31 - pos[5:0])];
    else dataBit = right_reg[5'(6'd31 - 6'(pos - {4'h0, wordLen}))];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dout_reg <= 1'b0;
      active_reg <= 1'b0;
    end else if (bitTick) begin
      active_reg <= pos < {3'b000, wordLen, 1'b0};
      dout_reg <= (pos < {3'b000, wordLen, 1'b0}) ? dataBit : 1'b0;
    end
  end
  assign frameActive = active_reg;

  // Word clock: one-bit pulse in DSP, otherwise a level that turns after the offset plus one word, one bit later in I2S
  always_ff @(posedge clk or posedge rst) begin
    if (rst) wclkLvl_reg <= 1'b0;
    else if (!divRun[1]) wclkLvl_reg <= 1'b0;
    else if (bitTick) begin
      if (fmt == FMT_DSP) wclkLvl_reg <= frameStart;
      else if (fmt == FMT_I2S) wclkLvl_reg <= !frameStart &&
        (bitCnt_reg + 10'd1 >= startBit + {4'h0, wordLen});
      else wclkLvl_reg <= frameStart ||
        (bitCnt_reg + 10'd1 < startBit + {4'h0, wordLen});
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) bclkLvl_reg <= 1'b0;
    else bclkLvl_reg <= divLvl_reg[1] ^ bclkInv;
  end

  assign bclkOut = bclkLvl_reg;
  assign bclkOe = bclkDrive;
  assign wclkOut = wclkLvl_reg;
  assign wclkOe = wclkDrive;
  assign doutOut = dout_reg;
  assign doutOe = !triEn || active_reg;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  AST_AUXILIARY_CLOCK_PIN_RSVD: assert property (@(posedge clk) disable iff (rst)
    clkSel_reg[2:0] == 3'b010 |-> !divTick_reg[0] [*2])
    else $error("aux divider ticked on reserved source");
  AST_AUXILIARY_CLOCK_PIN_OFF: assert property (@(posedge clk) disable iff (rst)
    !clkDiv_reg[DIV_PWR_BIT] |=> !auxClkOut)
    else $error("aux clock moved while powered down");
  AST_DIV_RATIO: assert property (@(posedge clk) disable iff (rst)
    divRun[0] && srcTick[0] && divCnt_reg[0] == 7'h7f
    |=> divCnt_reg[0] == 7'h00)
    else $error("aux divider did not wrap at top count");
  AST_BCLK_OFF: assert property (@(posedge clk) disable iff (rst)
    !divRun[1] |=> !divTick_reg[1] && divCnt_reg[1] == 7'h00)
    else $error("bit divider ran while stopped");
  AST_BCLK_DIR: assert property (@(posedge clk) disable iff (rst)
    bclkOe == portFmt_reg[BCLK_DIR_BIT])
    else $error("bit clock drive mismatch");
  AST_WCLK_DIR: assert property (@(posedge clk) disable iff (rst)
    $rose(portFmt_reg[WCLK_DIR_BIT]) |-> wclkOe)
    else $error("word clock drive mismatch");
  AST_TRISTATE: assert property (@(posedge clk) disable iff (rst)
    triEn && !active_reg |-> !doutOe)
    else $error("data driven outside active bits");
  AST_BCLK_SRC: assert property (@(posedge clk) disable iff (rst)
    portClk_reg[1:0] == BSEL_ADC && divRun[1] && !adcTick
    |=> !divTick_reg[1])
    else $error("bit divider ticked without its source");
  AST_INVERT: assert property (@(posedge clk) disable iff (rst)
    ##1 bclkOut == ($past(divLvl_reg[1]) ^ $past(bclkInv)))
    else $error("bit clock polarity wrong");
  AST_SHIFT: assert property (@(posedge clk) disable iff (rst)
    !bitTick |=> $stable(dout_reg))
    else $error("data moved without a bit clock");
  COV_FRAME: cover property (@(posedge clk) disable iff (rst)
    frameStart ##[1:700] frameStart);
  COV_DSP: cover property (@(posedge clk) disable iff (rst)
    fmt == FMT_DSP && wclkLvl_reg);
  COV_AUX: cover property (@(posedge clk) disable iff (rst)
    divTick_reg[0] && clkDiv_reg[6:0] == 7'h03);
  COV_TRI: cover property (@(posedge clk) disable iff (rst)
    triEn && $rose(doutOe));

endmodule

// ===== core/apc_pkg.sv
// Package for the audio port clock configuration block.
// Holds register indices, field positions, reset values and bus carriers.
package apc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_RSVD_A = 8'h17;
  localparam logic [7:0] IDX_RSVD_B = 8'h18;
  localparam logic [7:0] IDX_AUXILIARY_CLOCK_PIN_SEL = 8'h19;
  localparam logic [7:0] IDX_AUXILIARY_CLOCK_PIN_DIV = 8'h1a;
  localparam logic [7:0] IDX_PORT_FMT = 8'h1b;
  localparam logic [7:0] IDX_SLOT_OFS = 8'h1c;
  localparam logic [7:0] IDX_PORT_CLK = 8'h1d;
  localparam logic [7:0] IDX_BCLK_DIV = 8'h1e;
  localparam logic [7:0] IDX_STATUS = 8'h20;

  // Reset values
  localparam logic [7:0] RST_AUXILIARY_CLOCK_PIN_SEL = 8'h00;
  localparam logic [7:0] RST_AUXILIARY_CLOCK_PIN_DIV = 8'h01;
  localparam logic [7:0] RST_PORT_FMT = 8'h00;
  localparam logic [7:0] RST_SLOT_OFS = 8'h00;
  localparam logic [7:0] RST_PORT_CLK = 8'h02;
  localparam logic [7:0] RST_BCLK_DIV = 8'h01;

  // Writable bit masks; reserved bits keep their reset value
  localparam logic [7:0] MSK_AUXILIARY_CLOCK_PIN_SEL = 8'h07;
  localparam logic [7:0] MSK_PORT_FMT = 8'hfd;
  localparam logic [7:0] MSK_PORT_CLK = 8'h0f;

  // Field positions
  localparam int DIV_PWR_BIT = 7;
  localparam int FMT_LSB = 6;
  localparam int WLEN_LSB = 4;
  localparam int BCLK_DIR_BIT = 3;
  localparam int WCLK_DIR_BIT = 2;
  localparam int TRISTATE_BIT = 0;
  localparam int BCLK_INV_BIT = 3;
  localparam int KEEP_ALIVE_BIT = 2;

  // Clock output source codes
  localparam logic [2:0] CSEL_MCLK = 3'b000;
  localparam logic [2:0] CSEL_BCLK = 3'b001;
  localparam logic [2:0] CSEL_PLL = 3'b011;
  localparam logic [2:0] CSEL_ADC = 3'b110;
  localparam logic [2:0] CSEL_MOD = 3'b111;
  // Bit clock divider source codes
  localparam logic [1:0] BSEL_ADC = 2'b10;
  localparam logic [1:0] BSEL_MOD = 2'b11;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    FMT_I2S, FMT_DSP, FMT_RIGHT_JUSTIFIED, FMT_LEFT_JUSTIFIED
  } apc_fmt_e;

  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } apc_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } apc_axi_rsp_s;

endpackage

// ===== tb/apc_host_model.sv
// Far-side model of the host audio processor on the serial port.
// Assumes a single clk domain; bitPer is the bit period in clk cycles.
`timescale 1ns/1ps
module apc_host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench control
  input wire logic drive,
  input wire logic [15:0] bitPer,
  // Port pins
  output logic bclk,
  output logic wclk,
  input wire logic dout,
  input wire logic doutOe,
  // Capture results
  output logic [31:0] rxWord,
  output logic [15:0] lenLast,
  output logic [15:0] doneCnt
);
  logic [15:0] c;
  logic [15:0] ph;
  logic [15:0] len;
  logic [15:0] p;
  logic [5:0] b;
  logic oeQ;

  ////////////////////////////////////////////////////////////////////////////
  // Bit and word clock when the host is clock source
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      c <= 16'h0000;
      b <= 6'h00;
      bclk <= 1'b0;
      wclk <= 1'b0;
    end else if (drive) begin
      c <= (c == bitPer - 16'h0001) ? 16'h0000 : c + 16'h0001;
      bclk <= (c >= (bitPer >> 1));
      if (c == 16'h0000) begin
        // 64-bit frame leaves room for the start offset before the data
        b <= b + 6'h01;
        wclk <= (b >= 6'h1f) && (b != 6'h3f);
      end
    end else begin
      // Released: keep toggling so a stale level never looks like a drive
      bclk <= ~bclk;
      wclk <= ~wclk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture each data bit mid-period, timed from the output enable
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      oeQ <= 1'b0;
      ph <= 16'h0000;
      len <= 16'h0000;
      lenLast <= 16'h0000;
      doneCnt <= 16'h0000;
      rxWord <= 32'h0000_0000;
    end else begin
      oeQ <= doutOe;
      if (doutOe) begin
        p = oeQ ? ph : 16'h0000;
        if (p == (bitPer >> 1)) begin
          rxWord <= {rxWord[30:0], dout};
        end
        ph <= (p == bitPer - 16'h0001) ? 16'h0000 : p + 16'h0001;
        len <= oeQ ? len + 16'h0001 : 16'h0001;
      end else if (oeQ) begin
        lenLast <= len;
        doneCnt <= doneCnt + 16'h0001;
      end
    end
  end
endmodule

// ===== tb/audio_port_clock_config_tb_top.sv
// Self-checking bench for the audio port clock configuration block.
// Assumes apc_pkg and the host model are compiled first.
`timescale 1ns/1ps
module audio_port_clock_config_tb_top import apc_pkg::*;;
  localparam logic [31:0] LEFT_SMP = 32'hA5C3_0F96;
  localparam logic [31:0] RIGHT_SMP = 32'h3C5A_F00F;
  logic clk = 1'b0;
  logic rst = 1'b1;
  apc_axi_req_s axiReq = '0;
  apc_axi_rsp_s axiRsp;
  logic mclkTick = 1'b0, pllTick = 1'b0, adcTick = 1'b0, modTick = 1'b0;
  logic converterPowered = 1'b1;
  logic [31:0] sampleLeft = LEFT_SMP;
  logic [31:0] sampleRight = RIGHT_SMP;
  logic auxClkOut, bclkOut, bclkOe, wclkOut, wclkOe, doutOut, doutOe;
  logic hostBclk, hostWclk, hostDrive = 1'b0, probeSel = 1'b0;
  logic [15:0] bitPer = 16'h0008;
  logic [31:0] rxWord;
  logic [15:0] lenLast, doneCnt;
  logic [1:0] br;
  wire bclkWire = bclkOe ? bclkOut : hostBclk;
  wire wclkWire = wclkOe ? wclkOut : hostWclk;
  wire probe = probeSel ? bclkOut : auxClkOut;
  int cyc = 0;
  int err_total = 0;
  int tests_run = 0;

  apc_audio_port dut_u (.clk(clk), .rst(rst), .axiReq(axiReq),
    .axiRsp(axiRsp), .mclkTick(mclkTick), .pllTick(pllTick),
    .adcTick(adcTick), .modTick(modTick),
    .converterPowered(converterPowered), .auxClkOut(auxClkOut),
    .bclkIn(bclkWire), .bclkOut(bclkOut), .bclkOe(bclkOe),
    .wclkIn(wclkWire), .wclkOut(wclkOut), .wclkOe(wclkOe),
    .sampleLeft(sampleLeft), .sampleRight(sampleRight), .sampleTaken(),
    .doutOut(doutOut), .doutOe(doutOe));
  apc_host_model host_u (.clk(clk), .rst(rst), .drive(hostDrive),
    .bitPer(bitPer), .bclk(hostBclk), .wclk(hostWclk), .dout(doutOut),
    .doutOe(doutOe), .rxWord(rxWord), .lenLast(lenLast),
    .doneCnt(doneCnt));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and source ticks with periods 2, 3, 4 and 5 cycles
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    mclkTick <= (cyc % 2 == 0);
    pllTick <= (cyc % 3 == 0);
    adcTick <= (cyc % 4 == 0);
    modTick <= (cyc % 5 == 0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Response ready lines stay high, so only valids move here
  task automatic cfg(input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    axiReq.awaddr <= {22'h00_0000, idx, 2'b00};
    axiReq.wdata <= {24'h00_0000, d};
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready) axiReq.wvalid <= 1'b0;
    end while (axiRsp.bvalid !== 1'b1 && n < 200);
    br = axiRsp.bresp;
    if (n >= 200) err_total++;
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d);
    int n;
    n = 0;
    axiReq.araddr <= {22'h00_0000, idx, 2'b00};
    axiReq.arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (axiRsp.arready) axiReq.arvalid <= 1'b0;
    end while (axiRsp.rvalid !== 1'b1 && n < 200);
    d = axiRsp.rdata;
    br = axiRsp.rresp;
    if (n >= 200) err_total++;
  endtask

  // Period and high time of the probed clock; zero when it stays still
  task automatic measure(output int per, output int hi);
    int n;
    n = 0;
    per = 0;
    hi = 0;
    while (probe !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    while (probe !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n < 3000) begin
      while (probe === 1'b1 && hi < 3000) begin
        @(posedge clk);
        hi++;
      end
      per = hi;
      while (probe === 1'b0 && per < 3000) begin
        @(posedge clk);
        per++;
      end
    end
  endtask

  task automatic wait_frames(input int k);
    int n;
    logic [15:0] c0;
    n = 0;
    c0 = doneCnt;
    while (doneCnt != c0 + 16'(k) && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000) err_total++;
  endtask

  // Cycles from a word clock rising edge to the start of active data
  task automatic lag(output int l);
    l = 0;
    while (wclkOut !== 1'b0 && l < 3000) begin
      @(posedge clk);
      l++;
    end
    while (wclkOut !== 1'b1 && l < 3000) begin
      @(posedge clk);
      l++;
    end
    l = 0;
    while (doutOe !== 1'b1 && l < 3000) begin
      @(posedge clk);
      l++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    logic [7:0] ix[6] = '{IDX_AUXILIARY_CLOCK_PIN_SEL, IDX_AUXILIARY_CLOCK_PIN_DIV, IDX_PORT_FMT,
      IDX_SLOT_OFS, IDX_PORT_CLK, IDX_BCLK_DIV};
    logic [7:0] rv[6] = '{RST_AUXILIARY_CLOCK_PIN_SEL, RST_AUXILIARY_CLOCK_PIN_DIV, RST_PORT_FMT,
      RST_SLOT_OFS, RST_PORT_CLK, RST_BCLK_DIV};
    logic [31:0] d;
    for (int i = 0; i < 6; i++) begin
      rd(ix[i], d);
      check(d, {24'h00_0000, rv[i]});
    end
    rd(IDX_RSVD_A, d);
    check(32'(br), 32'(RESP_OKAY));
    rd(8'h40, d);
    check(32'(br), 32'(RESP_SLVERR));
    cfg(IDX_SLOT_OFS, 8'hff);
    rd(IDX_SLOT_OFS, d);
    check(d, 32'h0000_00ff);
  endtask

  task automatic t_aux();
    logic [2:0] src[4] = '{CSEL_MCLK, CSEL_PLL, CSEL_ADC, CSEL_MOD};
    int per, hi;
    probeSel <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      cfg(IDX_AUXILIARY_CLOCK_PIN_SEL, {5'h00, src[i]});
      cfg(IDX_AUXILIARY_CLOCK_PIN_DIV, 8'h83);
      measure(per, hi);
      check(32'(per), 32'(3 * (i + 2)));
      check(32'(hi), 32'(i + 2));
    end
    cfg(IDX_AUXILIARY_CLOCK_PIN_DIV, 8'h80);
    measure(per, hi);
    check(32'(per), 32'd640);
    cfg(IDX_AUXILIARY_CLOCK_PIN_DIV, 8'h03);
    measure(per, hi);
    check(32'(per), 32'd0);
  endtask

  task automatic t_bit();
    int per, hi;
    probeSel <= 1'b1;
    cfg(IDX_PORT_FMT, 8'h08);
    cfg(IDX_BCLK_DIV, 8'h83);
    measure(per, hi);
    check(32'(per), 32'd12);
    check(32'(hi), 32'd4);
    check(32'(bclkOe), 32'd1);
    cfg(IDX_PORT_CLK, 8'h0a);
    measure(per, hi);
    check(32'(hi), 32'd8);
    cfg(IDX_PORT_CLK, 8'h03);
    measure(per, hi);
    check(32'(per), 32'd15);
    converterPowered <= 1'b0;
    measure(per, hi);
    check(32'(per), 32'd0);
    cfg(IDX_PORT_CLK, 8'h07);
    measure(per, hi);
    check(32'(per), 32'd15);
    converterPowered <= 1'b1;
    cfg(IDX_BCLK_DIV, 8'h80);
    measure(per, hi);
    check(32'(per), 32'd640);
    cfg(IDX_BCLK_DIV, 8'h03);
    measure(per, hi);
    check(32'(per), 32'd0);
  endtask

  task automatic t_master();
    logic [63:0] full;
    int w, a, b;
    cfg(IDX_PORT_CLK, 8'h03);
    cfg(IDX_BCLK_DIV, 8'h82);
    bitPer <= 16'h000a;
    cfg(IDX_SLOT_OFS, 8'h02);
    // Format code and word length code step together
    for (int f = 0; f < 4; f++) begin
      w = (f == 3) ? 32 : 16 + 4 * f;
      cfg(IDX_PORT_FMT, {f[1:0], f[1:0], 4'hd});
      wait_frames(2);
      full = ({32'h0000_0000, LEFT_SMP >> (32 - w)} << w);
      full = full | 64'(RIGHT_SMP >> (32 - w));
      check(rxWord, full[31:0]);
      check(32'(lenLast), 32'(20 * w));
    end
    check(32'(wclkOe), 32'd1);
    cfg(IDX_PORT_FMT, 8'h4d);
    cfg(IDX_SLOT_OFS, 8'h00);
    // Zero offset fills the frame, so the data never goes idle to count
    lag(a);
    cfg(IDX_SLOT_OFS, 8'h03);
    wait_frames(1);
    lag(b);
    check(32'(b - a), 32'd30);
  endtask

  task automatic t_slave();
    int per, hi;
    bitPer <= 16'h0008;
    hostDrive <= 1'b1;
    cfg(IDX_PORT_FMT, 8'h01);
    check(32'(bclkOe), 32'd0);
    check(32'(wclkOe), 32'd0);
    wait_frames(2);
    check(rxWord, {LEFT_SMP[31:16], RIGHT_SMP[31:16]});
    check(32'(lenLast), 32'd256);
    probeSel <= 1'b0;
    cfg(IDX_AUXILIARY_CLOCK_PIN_SEL, {5'h00, CSEL_BCLK});
    cfg(IDX_AUXILIARY_CLOCK_PIN_DIV, 8'h82);
    measure(per, hi);
    check(32'(per), 32'd16);
    hostDrive <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Run control
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    axiReq.wstrb <= 4'hf;
    axiReq.bready <= 1'b1;
    axiReq.rready <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_aux();
    t_bit();
    t_master();
    t_slave();
    complete_run();
  end

  // Whole run is well under this; a hang lands here
  initial begin
    #2000000;
    err_total++;
    complete_run();
  end
endmodule
